// ---- src/ccp_core_clock_power.sv ----
// Purpose: clock and power control: strap decode, start-up, core run/mute/clear,
//          analog power-down levels and the bit clock on multipurpose pin eleven
// Assumes: classic Wishbone slave, 32-bit data, 8-bit registers in the low lane
// Notes:   one wait state on every access; unmapped addresses read zero
//
// Functional notes
// - setting core control bit 2 clears accumulators and data input and output registers.
// - one power-down for both input converters, one per output converter.
// - reference powers down only when power bits 6 and 7 are both set.
// - pin eleven drives divided core clock when set as bit clock and port is master.
// - oscillator runs by default and stops when its power-down bit is 1.
// - straps a,b decode 00=64x, 01=256x, 10=384x, 11=512x sample rate.
// - core clock comes from clk_i divided by 2, divided from master clock lock, ticks out only once boot ends, and runs at 25 MIPS.
// - start-up waits 2^18 master clock cycles; host waits for start-up and boot.
// - clock mode is taken from straps at reset release.
// - core control bits 4,3,2 are input mute, output mute, core run.
`timescale 1ns/100ps
`default_nettype none
module ccp_core_clock_power #(
	parameter int PLL_START_CYCLES = ccp_pkg::PLL_START_CYCLES
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [ccp_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [ccp_pkg::DAT_W-1:0] wb_dat_i,
	output logic      [ccp_pkg::DAT_W-1:0] wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     clock_ratio_strap_a_i,
	input  wire logic                     clock_ratio_strap_b_i,
	input  wire logic                     master_clock_in_i,
	input  wire logic                     multipurpose_pin_eleven_i,
	output logic                          multipurpose_pin_eleven_o,
	output logic                          multipurpose_pin_eleven_oe_o,
	output ccp_pkg::ccp_power_t           power_o,
	output logic                          input_converter_mute_o,
	output logic                          output_converter_mute_o,
	output logic                          core_halt_o,
	output logic                          core_clear_o,
	output logic                          core_tick_o,
	output ccp_pkg::ccp_rate_t            rate_mode_o,
	output logic [ccp_pkg::RATIO_W-1:0]   mclk_ratio_o,
	output logic                          core_ready_o
);
	localparam int RW = ccp_pkg::REG_W;
	localparam int DW = ccp_pkg::CORE_DIV_W;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one feeds stage two only
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	wire logic [3:0] pins_in = {multipurpose_pin_eleven_i, master_clock_in_i,
		clock_ratio_strap_b_i, clock_ratio_strap_a_i};

	// no reset: the straps must reach stage two while reset is still held
	always_ff @(posedge clk_i) begin
		sync_a <= pins_in;
		sync_b <= sync_a;
	end

	wire logic [1:0] strap_s = {sync_b[0], sync_b[1]};
	wire logic       mclk_s  = sync_b[2];
	wire logic       pin11_s = sync_b[3];

	////////////////////////////////////////////////////////////////////////
	// clock mode: follows the straps while reset is held, frozen from release on
	logic [1:0] strap_mode;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			strap_mode <= strap_s;
	end

	logic [ccp_pkg::RATIO_W-1:0] base_ratio;
	always_comb begin
		case (strap_mode)
			2'b00:   base_ratio = ccp_pkg::RATIO_64;
			2'b01:   base_ratio = ccp_pkg::RATIO_256;
			2'b10:   base_ratio = ccp_pkg::RATIO_384;
			2'b11:   base_ratio = ccp_pkg::RATIO_512;
			default: base_ratio = ccp_pkg::RATIO_64;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [RW-1:0] core_ctrl;
	logic [RW-1:0] sout_ctrl;
	logic [RW-1:0] mp_cfg;
	logic [RW-1:0] pwr_ctrl;
	logic [RW-1:0] osc_ctrl;
	logic          pll_locked;

	wire logic [ccp_pkg::IDX_W-1:0] idx = wb_adr_i[ccp_pkg::ADR_W-1:2];
	wire logic req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wr       = req & wb_we_i & wb_sel_i[0];
	wire logic hit_core = (idx == ccp_pkg::IDX_CORE_CTRL);
	wire logic hit_sout = (idx == ccp_pkg::IDX_SOUT_CTRL);
	wire logic hit_mp   = (idx == ccp_pkg::IDX_MP_CFG);
	wire logic hit_pwr  = (idx == ccp_pkg::IDX_PWR_CTRL);
	wire logic hit_osc  = (idx == ccp_pkg::IDX_OSC_PD);
	wire logic hit_stat = (idx == ccp_pkg::IDX_STATUS);
	wire logic [RW-1:0] wdat = wb_dat_i[RW-1:0];

	// status reports the ratio the host must supply for the chosen processing rate
	ccp_pkg::ccp_rate_t rate_mode;
	assign rate_mode = ccp_pkg::ccp_rate_t'(core_ctrl[ccp_pkg::RATE_LSB +: 2]);
	assign mclk_ratio_o = (rate_mode == ccp_pkg::CCP_RATE_QUAD)   ? (base_ratio >> 2) :
		(rate_mode == ccp_pkg::CCP_RATE_DOUBLE) ? (base_ratio >> 1) : base_ratio;

	wire logic [ccp_pkg::DAT_W-1:0] status_word =
		(ccp_pkg::DAT_W'(mclk_ratio_o) << ccp_pkg::ST_RATIO_LSB) |
		(ccp_pkg::DAT_W'(pin11_s) << ccp_pkg::ST_PIN_BIT) |
		(ccp_pkg::DAT_W'(strap_mode) << ccp_pkg::ST_STRAP_LSB) |
		(ccp_pkg::DAT_W'(core_ready_o) << ccp_pkg::ST_READY_BIT) |
		(ccp_pkg::DAT_W'(pll_locked) << ccp_pkg::ST_LOCK_BIT);

	wire logic [ccp_pkg::DAT_W-1:0] rd_mux =
		hit_core ? ccp_pkg::DAT_W'(core_ctrl) :
		hit_sout ? ccp_pkg::DAT_W'(sout_ctrl) :
		hit_mp   ? ccp_pkg::DAT_W'(mp_cfg) :
		hit_pwr  ? ccp_pkg::DAT_W'(pwr_ctrl) :
		hit_osc  ? ccp_pkg::DAT_W'(osc_ctrl) :
		hit_stat ? status_word : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_mux : '0;
		end
	end

	// a write takes effect at the acknowledging edge; outputs follow at that same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_ctrl <= ccp_pkg::REG_RESET;
			sout_ctrl <= ccp_pkg::REG_RESET;
			mp_cfg    <= ccp_pkg::REG_RESET;
			pwr_ctrl  <= ccp_pkg::REG_RESET;
			osc_ctrl  <= ccp_pkg::REG_RESET;
		end else if (wr) begin
			if (hit_core) core_ctrl <= wdat;
			if (hit_sout) sout_ctrl <= wdat;
			if (hit_mp)   mp_cfg    <= wdat;
			if (hit_pwr)  pwr_ctrl  <= wdat;
			if (hit_osc)  osc_ctrl  <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core run, mute and clear
	logic clear_pulse;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			clear_pulse <= 1'b0;
		else
			clear_pulse <= wr & hit_core & wdat[ccp_pkg::CORE_RUN_BIT];
	end

	assign core_clear_o            = clear_pulse;
	assign core_halt_o             = core_ctrl[ccp_pkg::CORE_RUN_BIT];
	assign input_converter_mute_o  = core_ctrl[ccp_pkg::IN_MUTE_BIT];
	assign output_converter_mute_o = core_ctrl[ccp_pkg::OUT_MUTE_BIT];
	assign rate_mode_o             = rate_mode;

	////////////////////////////////////////////////////////////////////////
	// analog power-down levels, straight from register bits
	assign power_o = '{
		osc_pd: osc_ctrl[ccp_pkg::OSC_PD_BIT],
		// both bits needed so a single stray bit cannot drop the shared reference
		ref_pd: pwr_ctrl[ccp_pkg::REF_PD_A] & pwr_ctrl[ccp_pkg::REF_PD_B],
		dac_pd: pwr_ctrl[ccp_pkg::DAC_PD_LSB +: ccp_pkg::NUM_DAC],
		adc_pd: pwr_ctrl[ccp_pkg::ADC_PD_BIT]
	};

	////////////////////////////////////////////////////////////////////////
	// start-up and core instruction rate
	ccp_pll_start #(
		.START_CYCLES (PLL_START_CYCLES)
	) u_start (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.mclk_level_i (mclk_s),
		.locked_o     (pll_locked),
		.ready_o      (core_ready_o)
	);

	logic [DW-1:0] div_cnt;
	wire logic     tick_raw = pll_locked && (div_cnt == DW'(ccp_pkg::CORE_DIV - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || !pll_locked)
			div_cnt <= '0;
		else
			div_cnt <= tick_raw ? '0 : div_cnt + DW'(1);
	end

	assign core_tick_o = tick_raw & core_ready_o & ~core_halt_o;

	////////////////////////////////////////////////////////////////////////
	// bit clock on pin eleven: half period is 1, 2, 4 or 8 core cycles
	wire logic [1:0] obf      = sout_ctrl[ccp_pkg::OBF_LSB +: 2];
	wire logic       bclk_en  = (mp_cfg[ccp_pkg::MULTIPURPOSE_PIN_ELEVEN_MODE_LSB +: 2] == ccp_pkg::MULTIPURPOSE_PIN_ELEVEN_MODE_BCLK) &&
		sout_ctrl[ccp_pkg::SOUT_MASTER_BIT];
	wire logic [3:0] half_m1  = 4'((4'h1 << obf) - 4'h1);
	logic [3:0]      bclk_cnt;
	logic            bclk;

	always_ff @(posedge clk_i) begin
		if (rst_i || !bclk_en) begin
			bclk_cnt <= '0;
			bclk     <= 1'b0;
		end else if (tick_raw) begin
			bclk_cnt <= (bclk_cnt >= half_m1) ? '0 : bclk_cnt + 4'h1;
			if (bclk_cnt >= half_m1)
				bclk <= ~bclk;
		end
	end

	assign multipurpose_pin_eleven_o    = bclk;
	assign multipurpose_pin_eleven_oe_o = bclk_en;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_clear_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(wr && hit_core && wdat[ccp_pkg::CORE_RUN_BIT]) |=> core_clear_o ##1 (core_halt_o && !core_tick_o);
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("core clear missing after write");

	property p_mute_bits;
		@(posedge clk_i) disable iff (rst_i)
		(wr && hit_core) |=> input_converter_mute_o == $past(wdat[ccp_pkg::IN_MUTE_BIT]) &&
			output_converter_mute_o == $past(wdat[ccp_pkg::OUT_MUTE_BIT]);
	endproperty
	a_mute_bits: assert property (p_mute_bits) else $error("mute level not taken from write");

	property p_pd_reset;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> power_o == '0;
	endproperty
	a_pd_reset: assert property (p_pd_reset) else $error("power-down bits not clear after reset");

	property p_pd_write;
		@(posedge clk_i) disable iff (rst_i)
		(wr && hit_pwr) |=> power_o.adc_pd == $past(wdat[ccp_pkg::ADC_PD_BIT]) &&
			power_o.dac_pd == $past(wdat[ccp_pkg::DAC_PD_LSB +: ccp_pkg::NUM_DAC]);
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("power-down level late or wrong");

	property p_ref_pd;
		@(posedge clk_i) disable iff (rst_i)
		(wr && hit_pwr) |=> power_o.ref_pd == ($past(wdat[ccp_pkg::REF_PD_A]) && $past(wdat[ccp_pkg::REF_PD_B]));
	endproperty
	a_ref_pd: assert property (p_ref_pd) else $error("reference power-down not both bits");

	property p_osc_pd;
		@(posedge clk_i) disable iff (rst_i)
		(wr && hit_osc) |=> power_o.osc_pd == $past(wdat[ccp_pkg::OSC_PD_BIT]);
	endproperty
	a_osc_pd: assert property (p_osc_pd) else $error("oscillator power-down not applied");

	property p_strap_frozen;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> $stable(strap_mode);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen) else $error("clock mode changed outside reset");

	property p_core_rate;
		@(posedge clk_i) disable iff (rst_i)
		core_tick_o |=> !core_tick_o;
	endproperty
	a_core_rate: assert property (p_core_rate) else $error("core tick faster than core rate");

	property p_bclk_edges;
		@(posedge clk_i) disable iff (rst_i)
		($changed(multipurpose_pin_eleven_o) && $past(bclk_en) && bclk_en) |-> $past(tick_raw);
	endproperty
	a_bclk_edges: assert property (p_bclk_edges) else $error("bit clock edge off the core clock");

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle after request");
endmodule : ccp_core_clock_power
`default_nettype wire

// ---- pkg/ccp_pkg.sv ----
// Purpose: shared constants, register map and types for the core clock and power control block
// Assumes: 50 MHz system clock, classic Wishbone register access with 32-bit data
// Notes:   register indices are word indices; the byte address is four times the index
package ccp_pkg;
	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS    = 20;
	localparam int CLK_MHZ          = 1000 / CLK_PERIOD_NS;
	localparam int CORE_MIPS        = 25;
	localparam int CORE_DIV         = CLK_MHZ / CORE_MIPS;
	localparam int CORE_DIV_W       = (CORE_DIV > 1) ? $clog2(CORE_DIV) : 1;
	localparam int PLL_START_CYCLES = 32'h0004_0000;
	localparam int BOOT_TIME_NS     = 42000;
	localparam int BOOT_CYCLES      = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// bus and register map
	localparam int ADR_W = 16;
	localparam int IDX_W = 14;
	localparam int DAT_W = 32;
	localparam int REG_W = 8;
	localparam logic [IDX_W-1:0] IDX_CORE_CTRL = 14'h081C;
	localparam logic [IDX_W-1:0] IDX_SOUT_CTRL = 14'h081E;
	localparam logic [IDX_W-1:0] IDX_MP_CFG    = 14'h0821;
	localparam logic [IDX_W-1:0] IDX_PWR_CTRL  = 14'h0824;
	localparam logic [IDX_W-1:0] IDX_OSC_PD    = 14'h0825;
	localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h0826;
	localparam logic [REG_W-1:0] REG_RESET     = 8'h00;

	// core control fields
	localparam int RATE_LSB     = 0;
	localparam int CORE_RUN_BIT = 2;
	localparam int OUT_MUTE_BIT = 3;
	localparam int IN_MUTE_BIT  = 4;
	// serial output control fields
	localparam int SOUT_MASTER_BIT = 0;
	localparam int OBF_LSB         = 1;
	// multipurpose configuration fields
	localparam int MULTIPURPOSE_PIN_ELEVEN_MODE_LSB          = 0;
	localparam logic [1:0] MULTIPURPOSE_PIN_ELEVEN_MODE_BCLK = 2'h1;
	// power control and oscillator power-down fields
	localparam int ADC_PD_BIT = 0;
	localparam int DAC_PD_LSB = 1;
	localparam int NUM_DAC    = 4;
	localparam int REF_PD_A   = 6;
	localparam int REF_PD_B   = 7;
	localparam int OSC_PD_BIT = 0;
	// status fields
	localparam int ST_LOCK_BIT  = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_STRAP_LSB = 2;
	localparam int ST_PIN_BIT   = 4;
	localparam int ST_RATIO_LSB = 8;

	////////////////////////////////////////////////////////////////////////
	// master clock ratios, multiples of the sample rate
	localparam int RATIO_W = 10;
	localparam logic [RATIO_W-1:0] RATIO_64  = 10'h040;
	localparam logic [RATIO_W-1:0] RATIO_256 = 10'h100;
	localparam logic [RATIO_W-1:0] RATIO_384 = 10'h180;
	localparam logic [RATIO_W-1:0] RATIO_512 = 10'h200;

	typedef enum logic [1:0] {
		CCP_RATE_FULL   = 2'b00,
		CCP_RATE_DOUBLE = 2'b01,
		CCP_RATE_QUAD   = 2'b10
	} ccp_rate_t;

	typedef enum logic [1:0] {
		CCP_ST_PLL   = 2'b00,
		CCP_ST_BOOT  = 2'b01,
		CCP_ST_READY = 2'b10
	} ccp_start_t;

	typedef struct packed {
		logic               osc_pd;
		logic               ref_pd;
		logic [NUM_DAC-1:0] dac_pd;
		logic               adc_pd;
	} ccp_power_t;
endpackage : ccp_pkg

// ---- src/ccp_pll_start.sv ----
// Purpose: start-up timer, counts master clock edges until lock, then the boot interval
// Assumes: mclk_level_i is already synchronised to clk_i
// Notes:   the master clock must be much slower than clk_i / 2 to be counted reliably
`timescale 1ns/100ps
`default_nettype none
module ccp_pll_start #(
	parameter int START_CYCLES = ccp_pkg::PLL_START_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic mclk_level_i,
	output logic      locked_o,
	output logic      ready_o
);
	localparam int SW = $clog2(START_CYCLES + 1);
	localparam int BW = $clog2(ccp_pkg::BOOT_CYCLES + 1);

	ccp_pkg::ccp_start_t state;
	ccp_pkg::ccp_start_t next_state;
	logic [SW-1:0]       cnt;
	logic [BW-1:0]       bcnt;
	logic                mclk_prev;
	wire logic           mclk_rise = mclk_level_i & ~mclk_prev;
	wire logic           pll_done  = mclk_rise && (cnt == SW'(START_CYCLES - 1));
	wire logic           boot_done = (bcnt == BW'(ccp_pkg::BOOT_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (state)
			ccp_pkg::CCP_ST_PLL:   next_state = pll_done ? ccp_pkg::CCP_ST_BOOT : state;
			ccp_pkg::CCP_ST_BOOT:  next_state = boot_done ? ccp_pkg::CCP_ST_READY : state;
			ccp_pkg::CCP_ST_READY: next_state = state;
			default:               next_state = ccp_pkg::CCP_ST_PLL;
		endcase
	end

	// counting restarts from zero on every reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= ccp_pkg::CCP_ST_PLL;
			cnt       <= '0;
			bcnt      <= '0;
			// primed with the pin level so a high master clock gives no false edge after reset
			mclk_prev <= mclk_level_i;
		end else begin
			state     <= next_state;
			mclk_prev <= mclk_level_i;
			if (state == ccp_pkg::CCP_ST_PLL && mclk_rise)
				cnt <= cnt + SW'(1);
			if (state == ccp_pkg::CCP_ST_BOOT)
				bcnt <= bcnt + BW'(1);
		end
	end

	assign locked_o = (state != ccp_pkg::CCP_ST_PLL);
	assign ready_o  = (state == ccp_pkg::CCP_ST_READY);

	////////////////////////////////////////////////////////////////////////
	property p_lock_count;
		@(posedge clk_i) disable iff (rst_i)
		$rose(locked_o) |-> ($past(cnt) == SW'(START_CYCLES - 1)) && $past(mclk_rise);
	endproperty
	a_lock_count: assert property (p_lock_count) else $error("lock before full master clock count");

	property p_ready_after_lock;
		@(posedge clk_i) disable iff (rst_i)
		$rose(ready_o) |-> $past(locked_o) && $past(bcnt) == BW'(ccp_pkg::BOOT_CYCLES - 1);
	endproperty
	a_ready_after_lock: assert property (p_ready_after_lock) else $error("ready without full boot time");
endmodule : ccp_pll_start
`default_nettype wire

// ---- testbench/ccp_partner.sv ----
// Purpose: master clock source in front of the clock and power control block
// Assumes: runs from power-up at clk_i / 8, much slower than clk_i / 2
// Notes:   free running, phase unrelated to clk_i
`timescale 1ns/100ps
`default_nettype none
module ccp_partner #(
	parameter int HALF_NS = 80
) (
	output logic master_clock_o
);
	initial begin
		master_clock_o = 1'h0;
		#7;
		forever #(HALF_NS) master_clock_o = ~master_clock_o;
	end
endmodule : ccp_partner
`default_nettype wire

// ---- testbench/ccp_core_clock_power_test.sv ----
// Purpose: self-checking bench for ccp_core_clock_power
// Assumes: short start count of 16 master clock edges
// Notes:   table rows cover register writes, hand tests cover the rest
`timescale 1ns/100ps
`default_nettype none
module ccp_core_clock_power_test;
	typedef struct packed {
		logic [13:0] idx;
		logic [7:0]  data;
		logic [9:0]  exp;
	} ccp_row_t;
	logic                clk_i, rst_i, cyc, stb, we, sa, sb, pin_i, ack, pin_o, pin_oe;
	logic                in_mute, out_mute, halt, clr, tick, ready, mclk, clr_seen;
	logic [15:0]         adr;
	logic [3:0]          sel;
	logic [31:0]         wdat, rdat, rd;
	logic [9:0]          ratio;
	ccp_pkg::ccp_power_t power;
	ccp_pkg::ccp_rate_t  rate;
	int                  n_mismatch, n_checks, cyc_cnt, k, t;
	localparam logic [13:0] CORE = ccp_pkg::IDX_CORE_CTRL;
	localparam logic [13:0] PWR  = ccp_pkg::IDX_PWR_CTRL;
	localparam logic [13:0] OSC  = ccp_pkg::IDX_OSC_PD;
	localparam logic [13:0] STS  = ccp_pkg::IDX_STATUS;
	logic [9:0] ratios [4] = '{ccp_pkg::RATIO_64, ccp_pkg::RATIO_256, ccp_pkg::RATIO_384, ccp_pkg::RATIO_512};
	// expected {power_o, input mute, output mute, halt}
	ccp_row_t rows [11] = '{
		'{PWR, 8'h01, 10'h008}, '{PWR, 8'h1e, 10'h0f0}, '{PWR, 8'h40, 10'h000},
		'{PWR, 8'h80, 10'h000}, '{PWR, 8'hff, 10'h1f8}, '{OSC, 8'h01, 10'h3f8},
		'{CORE, 8'h18, 10'h3fe}, '{CORE, 8'h1c, 10'h3ff}, '{CORE, 8'h00, 10'h3f8},
		'{PWR, 8'h00, 10'h200}, '{OSC, 8'h00, 10'h000}};

	ccp_partner i_src (.master_clock_o(mclk));
	ccp_core_clock_power #(.PLL_START_CYCLES(16)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.clock_ratio_strap_a_i(sa), .clock_ratio_strap_b_i(sb), .master_clock_in_i(mclk),
		.multipurpose_pin_eleven_i(pin_i), .multipurpose_pin_eleven_o(pin_o),
		.multipurpose_pin_eleven_oe_o(pin_oe), .power_o(power), .input_converter_mute_o(in_mute),
		.output_converter_mute_o(out_mute), .core_halt_o(halt), .core_clear_o(clr),
		.core_tick_o(tick), .rate_mode_o(rate), .mclk_ratio_o(ratio), .core_ready_o(ready));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// request held until ack is sampled high, released at that edge
	task xfer(input logic w, input logic [13:0] idx, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {idx, 2'h0};
		sel <= s;
		wdat <= 32'(d);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1 && n < 50);
		rd = rdat;
		clr_seen = clr;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		chk("ack", 32'(ack), 32'h0000_0001);
	endtask : xfer

	task count_ticks(input logic [31:0] exp);
		t = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (tick === 1'h1)
				t++;
		end
		chk("ticks", t, exp);
	endtask : count_ticks

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, cyc, stb, we, sa, sb, pin_i} = 7'h41;
		adr = 16'h0000;
		sel = 4'h0;
		wdat = 32'h0000_0000;
		// straps change only while reset is held
		for (k = 0; k < 4; k++) begin
			@(posedge clk_i);
			rst_i <= 1'h1;
			{sa, sb} <= k[1:0];
			repeat (8) @(posedge clk_i);
			rst_i <= 1'h0;
			repeat (2) @(posedge clk_i);
			chk("ratio", 32'(ratio), 32'(ratios[k]));
			chk("rate", 32'(rate), 32'h0000_0000);
		end
		chk("reset_outs", {power, in_mute, out_mute, halt, pin_oe, ready}, 32'h0000_0000);
		repeat (40) @(posedge clk_i);
		chk("early_ready", 32'(ready), 32'h0000_0000);
		t = 0;
		while (ready !== 1'h1 && t < 5000) begin
			@(posedge clk_i);
			t++;
		end
		chk("ready", 32'(ready), 32'h0000_0001);
		chk("boot_wait", 32'(t >= 2100), 32'h0000_0001);
		xfer(1'h0, STS, 8'h00, 4'hf);
		chk("status", rd, 32'h0002_001f);
		for (k = 0; k < 11; k++) begin
			xfer(1'h1, rows[k].idx, rows[k].data, 4'hf);
			chk("clear", 32'(clr_seen), 32'(rows[k].idx == CORE && rows[k].data[2]));
			chk("outs", {power, in_mute, out_mute, halt}, 32'(rows[k].exp));
			xfer(1'h0, rows[k].idx, 8'h00, 4'hf);
			chk("readback", rd, 32'(rows[k].data));
		end
		for (k = 1; k < 3; k++) begin
			xfer(1'h1, CORE, k[7:0], 4'hf);
			chk("rate", 32'(rate), k);
			chk("ratio", 32'(ratio), 32'(ccp_pkg::RATIO_512 >> k));
		end
		xfer(1'h1, CORE, 8'h00, 4'hf);
		xfer(1'h1, 14'h0100, 8'hff, 4'hf);
		xfer(1'h0, 14'h0100, 8'h00, 4'hf);
		chk("unmapped", rd, 32'h0000_0000);
		xfer(1'h1, PWR, 8'h01, 4'h0);
		chk("sel_off", 32'(power), 32'h0000_0000);
		xfer(1'h1, STS, 8'h00, 4'hf);
		xfer(1'h0, STS, 8'h00, 4'hf);
		chk("status_ro", rd, 32'h0002_001f);
		pin_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		xfer(1'h0, STS, 8'h00, 4'hf);
		chk("status_pin", rd, 32'h0002_000f);
		count_ticks(10);
		xfer(1'h1, CORE, 8'h04, 4'hf);
		count_ticks(0);
		xfer(1'h1, CORE, 8'h00, 4'hf);
		xfer(1'h1, ccp_pkg::IDX_MP_CFG, 8'h01, 4'hf);
		chk("oe_slave", 32'(pin_oe), 32'h0000_0000);
		for (k = 0; k < 4; k++) begin
			xfer(1'h1, ccp_pkg::IDX_SOUT_CTRL, 8'((k << 1) | 1), 4'hf);
			chk("oe_master", 32'(pin_oe), 32'h0000_0001);
			t = 0;
			while (pin_o !== 1'h0 && t < 100) begin
				@(posedge clk_i);
				t++;
			end
			while (pin_o !== 1'h1 && t < 100) begin
				@(posedge clk_i);
				t++;
			end
			t = 0;
			while (pin_o === 1'h1 && t < 100) begin
				@(posedge clk_i);
				t++;
			end
			chk("bclk_high", t, 2 << k);
		end
		wrap_up();
	end
endmodule : ccp_core_clock_power_test
`default_nettype wire
